// >>> src/vrec_top.sv
// virtual and translation RAM ECC error records with register access
//
// Strobed register access and the placing of the registers were left to the implementer.
`include "vrec_cfg.svh"
module vrec_top (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  input  wire logic [`VREC_NUM_SRC-1:0]      ce_evt,
  input  wire logic [`VREC_NUM_SRC-1:0]      ue_evt,
  input  wire logic [`VREC_NUM_SRC-1:0][31:0] evt_bitloc,
  input  wire logic [`VREC_NUM_SRC-1:0][31:0] evt_addr,
  input  wire logic [7:0]                    its_index,
  input  wire logic [1:0]                    its_ram_sel,
  output logic                               irq_virtual_comm_cache,
  output logic                               irq_virtual_sgi_pending_array,
  output logic                               irq_virtual_target_store,
  output logic                               irq_virtual_target_residency,
  output logic                               irq_virtual_target_search,
  output logic                               its_refetch_req,
  output logic      [1:0]                    its_refetch_ram,
  output logic      [31:0]                   its_refetch_addr
);

  // ----------------------------------------------------------------------
  // record slots, two per source: even correctable, odd uncorrectable
  // ----------------------------------------------------------------------
  localparam int NREC = 2 * `VREC_NUM_SRC;

  logic [NREC-1:0]       rec_valid;
  logic [NREC-1:0]       rec_ovf;
  logic [NREC-1:0][31:0] rec_syn;
  logic [NREC-1:0]       rec_clr;
  logic [NREC-1:0]       rec_present;
  logic [NREC-1:0]       rec_evt;
  logic [NREC-1:0][31:0] rec_syn_in;

  logic [1:0] rgn;
  logic [5:0] rnum;
  logic [5:0] ridx;
  logic       rhit;

  // record index from the low address bits
  always_comb begin
    rgn  = reg_addr[7:6];
    rnum = reg_addr[5:0];
    ridx = rnum - 6'(`VREC_REC_FIRST);
    rhit = (rnum >= 6'(`VREC_REC_FIRST)) && (rnum <= 6'(`VREC_REC_LAST));
  end

  genvar g;
  generate
    for (g = 0; g < `VREC_NUM_SRC; g++) begin : g_src
      logic [31:0] ce_s;
      logic [31:0] ue_s;

      vrec_syn_fmt #(
        .SRC (g)
      ) u_fmt (
        .bitloc  (evt_bitloc[g]),
        .addr    (evt_addr[g]),
        .its_idx (its_index),
        .its_ram (its_ram_sel),
        .ce_syn  (ce_s),
        .ue_syn  (ue_s)
      );

      // correctable in the lower record number, uncorrectable in the next
      assign rec_evt[2*g]        = ce_evt[g];
      assign rec_evt[2*g+1]      = ue_evt[g];
      assign rec_syn_in[2*g]     = ce_s;
      assign rec_syn_in[2*g+1]   = ue_s;
      // virtual records need v4 support, last pair needs a translation service
      assign rec_present[2*g]    = (g == 5) ? (`VREC_ITS_EN != 0)
                                            : (`VREC_V4_EN != 0);
      assign rec_present[2*g+1]  = rec_present[2*g];
    end

    for (g = 0; g < NREC; g++) begin : g_rec
      // write one to the valid bit of the status word clears the record
      assign rec_clr[g] = reg_wr && rhit && (rgn == `VREC_RGN_STAT) &&
                          (ridx == 6'(g)) && reg_wdata[`VREC_STAT_VALID];

      vrec_slot u_slot (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .present  (rec_present[g]),
        .evt      (rec_evt[g]),
        .syn_in   (rec_syn_in[g]),
        .clr      (rec_clr[g]),
        .valid    (rec_valid[g]),
        .ovf      (rec_ovf[g]),
        .syn      (rec_syn[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // state: read data, interrupt levels, refetch request
  // ----------------------------------------------------------------------
  vrec_pkg::vrec_top_s st_ff;
  vrec_pkg::vrec_top_s nxt_st;
  logic [31:0]         cfg_word;

  always_comb begin
    cfg_word = {8'h00, 8'(`VREC_ITS_LOG2), 4'(`VREC_CORES_LOG2),
                6'(`VREC_VPE_WIDTH), 4'h0,
                1'(`VREC_ITS_EN), 1'(`VREC_V4_EN)};
    nxt_st = st_ff;
    // read data holds only in the cycle after the strobe
    nxt_st.rdata = 32'h00000000;
    if (reg_rd) begin
      if (reg_addr == `VREC_CFG_ADDR) begin
        nxt_st.rdata = cfg_word;
      end else if (rhit) begin
        case (rgn)
          `VREC_RGN_SYN: begin
            nxt_st.rdata = rec_syn[ridx[3:0]];
          end
          `VREC_RGN_STAT: begin
            nxt_st.rdata = {30'h00000000, rec_ovf[ridx[3:0]], rec_valid[ridx[3:0]]};
          end
          default: begin
            nxt_st.rdata = 32'h00000000;
          end
        endcase
      end
    end
    // level irq per virtual RAM, held while either of its records is valid
    for (int i = 0; i < 5; i++) begin
      nxt_st.irq[i] = rec_valid[2*i] | rec_valid[2*i+1];
    end
    // uncorrectable translation error: ask for the entry again, no software step;
    // fires on every error, even when the record is already occupied
    nxt_st.refetch = ue_evt[5] && rec_present[11];
    if (ue_evt[5]) begin
      nxt_st.refetch_ram  = its_ram_sel;
      nxt_st.refetch_addr = evt_addr[5];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata                     = st_ff.rdata;
  assign irq_virtual_comm_cache        = st_ff.irq[0];
  assign irq_virtual_sgi_pending_array = st_ff.irq[1];
  assign irq_virtual_target_store      = st_ff.irq[2];
  assign irq_virtual_target_residency  = st_ff.irq[3];
  assign irq_virtual_target_search     = st_ff.irq[4];
  assign its_refetch_req               = st_ff.refetch;
  assign its_refetch_ram               = st_ff.refetch_ram;
  assign its_refetch_addr              = st_ff.refetch_addr;

endmodule

// >>> src/vrec_cfg.svh
// constants for the virtual RAM ECC error record block
//
// Notes on behaviour
// - comm cache correctable errors log in record 15, uncorrectable in 16; raise its irq.
// - records 15 and 16 exist only with fourth-generation virtual support.
// - comm cache correctable syndrome: bit location above, address below; uncorrectable: address only.
// - vPE count is two to the vPE width; width sizes syndrome address fields.
// - pending array correctable errors in record 17, uncorrectable in 18; raise its irq.
// - records 17 and 18 exist only with fourth-generation virtual support.
// - pending array: width up to 8 gives one address bit, else width minus 7.
// - target store correctable errors in record 19, uncorrectable in 20; raise its irq.
// - target store address is vpe_width bits, bit location above up to bit 31.
// - target residency correctable errors in record 21, uncorrectable in 22; raise irq.
// - residency syndrome address is log2(cores) bits, bit location above it.
// - records 19 through 24 exist only with fourth-generation virtual support.
// - target search correctable errors in record 23, uncorrectable in 24; raise irq.
// - target search syndrome split equals the pending array split.
// - translation RAM correctable errors in record 25, uncorrectable in 26.
// - records 25 and 26 exist only when a translation service is configured.
// - translation uncorrectable error triggers an automatic refetch of the entry.
// - translation correctable: index, selector, 8-bit location, address from x+10.
// - translation uncorrectable: index, 3-bit selector at x, address from x+3.
// - selector codes: none, device cache, collection cache, event cache as 0 to 3.
`ifndef VREC_CFG_SVH
`define VREC_CFG_SVH

// ----------------------------------------------------------------------
// build configuration
// ----------------------------------------------------------------------
`define VREC_V4_EN          1
`define VREC_ITS_EN         1
`define VREC_VPE_WIDTH      10
`define VREC_CORES_LOG2     4
`define VREC_ITS_LOG2       1

// ----------------------------------------------------------------------
// record numbering and syndrome split
// ----------------------------------------------------------------------
`define VREC_NUM_SRC        6
`define VREC_REC_FIRST      15
`define VREC_REC_LAST       26
`define VREC_SPA_SPLIT      8
`define VREC_SPA_ROW_LOG2   7
`define VREC_ITS_BL_OFS     2
`define VREC_ITS_CE_AD_OFS  10
`define VREC_ITS_UE_AD_OFS  3
`define VREC_ITS_BL_W       8

// ----------------------------------------------------------------------
// register map, word addresses
// ----------------------------------------------------------------------
`define VREC_RGN_SYN        2'h0
`define VREC_RGN_STAT       2'h1
`define VREC_CFG_ADDR       8'h80
`define VREC_STAT_VALID     0
`define VREC_STAT_OVF       1
`define VREC_SYN_RST        32'h00000000

`endif

// >>> src/vrec_pkg.sv
// types shared by the virtual RAM ECC error record block
package vrec_pkg;

  // translation RAM selector, codes in declaration order
  typedef enum logic [1:0] {
    VREC_SEL_NONE,
    VREC_SEL_DEVICE,
    VREC_SEL_COLLECTION,
    VREC_SEL_EVENT
  } vrec_ram_sel_e;

  typedef struct packed {
    logic        valid;
    logic        ovf;
    logic [31:0] syn;
  } vrec_slot_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic [4:0]  irq;
    logic        refetch;
    logic [1:0]  refetch_ram;
    logic [31:0] refetch_addr;
  } vrec_top_s;

endpackage

// >>> src/vrec_syn_fmt.sv
// syndrome packing for one RAM source
`include "vrec_cfg.svh"
module vrec_syn_fmt #(
  parameter int SRC = 0
) (
  input  wire logic [31:0] bitloc,
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  its_idx,
  input  wire logic [1:0]  its_ram,
  output logic      [31:0] ce_syn,
  output logic      [31:0] ue_syn
);

  // ----------------------------------------------------------------------
  // address field width per source
  // ----------------------------------------------------------------------
  localparam int VW = `VREC_VPE_WIDTH;
  localparam int SPA_AW = (VW <= `VREC_SPA_SPLIT) ? 1 : VW - `VREC_SPA_ROW_LOG2;
  localparam int AW = (SRC == 0) ? $clog2(VW) :
                      (SRC == 2) ? VW :
                      (SRC == 3) ? `VREC_CORES_LOG2 :
                      SPA_AW;
  localparam int X = `VREC_ITS_LOG2;

  logic [31:0] amask;
  logic [31:0] imask;
  logic [31:0] blmask;

  always_comb begin
    amask  = (32'h00000001 << AW) - 32'h00000001;
    imask  = (32'h00000001 << X) - 32'h00000001;
    blmask = (32'h00000001 << `VREC_ITS_BL_W) - 32'h00000001;
    if (SRC == 5) begin
      ce_syn = (addr << (X + `VREC_ITS_CE_AD_OFS)) |
               ((bitloc & blmask) << (X + `VREC_ITS_BL_OFS)) |
               ({30'h00000000, its_ram} << X) | ({24'h000000, its_idx} & imask);
      ue_syn = (addr << (X + `VREC_ITS_UE_AD_OFS)) |
               ({30'h00000000, its_ram} << X) | ({24'h000000, its_idx} & imask);
    end else begin
      ce_syn = (bitloc << AW) | (addr & amask);
      ue_syn = addr & amask;
    end
  end

endmodule

// >>> src/vrec_slot.sv
// one error record: valid, overflow and held syndrome
module vrec_slot (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        present,
  input  wire logic        evt,
  input  wire logic [31:0] syn_in,
  input  wire logic        clr,
  output logic             valid,
  output logic             ovf,
  output logic      [31:0] syn
);

  vrec_pkg::vrec_slot_s st_ff;
  vrec_pkg::vrec_slot_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (clr) begin
      nxt_st.valid = 1'b0;
      nxt_st.ovf   = 1'b0;
    end
    // event beats a clear in the same cycle
    if (present && evt) begin
      if (st_ff.valid && !clr) begin
        nxt_st.ovf = 1'b1;
      end else begin
        nxt_st.valid = 1'b1;
        nxt_st.syn   = syn_in;
      end
    end
    if (!present) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign valid = st_ff.valid;
  assign ovf   = st_ff.ovf;
  assign syn   = st_ff.syn;

endmodule

// >>> tb/vrec_top_chk.sv
// assertion checker for the virtual RAM ECC error record block
`include "vrec_cfg.svh"
module vrec_top_chk (
  input wire logic                           core_clk,
  input wire logic                           rst_n,
  input wire logic                           reg_wr,
  input wire logic                           reg_rd,
  input wire logic [31:0]                    reg_rdata,
  input wire logic [`VREC_NUM_SRC-1:0]       ce_evt,
  input wire logic [`VREC_NUM_SRC-1:0]       ue_evt,
  input wire logic [`VREC_NUM_SRC-1:0][31:0] evt_addr,
  input wire logic [1:0]                     its_ram_sel,
  input wire logic                           irq_virtual_comm_cache,
  input wire logic                           irq_virtual_sgi_pending_array,
  input wire logic                           irq_virtual_target_store,
  input wire logic                           irq_virtual_target_residency,
  input wire logic                           irq_virtual_target_search,
  input wire logic                           its_refetch_req,
  input wire logic [1:0]                     its_refetch_ram,
  input wire logic [31:0]                    its_refetch_addr
);
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // capture raises the level two edges later
  // ------------------------------------------------------------
  AST_IRQ_CC: assert property ((ce_evt[0] | ue_evt[0]) |-> ##2 irq_virtual_comm_cache)
    else $error("comm cache irq missing");
  AST_IRQ_SPA: assert property ((ce_evt[1] | ue_evt[1]) |-> ##2 irq_virtual_sgi_pending_array)
    else $error("pending array irq missing");
  AST_IRQ_VST: assert property ((ce_evt[2] | ue_evt[2]) |-> ##2 irq_virtual_target_store)
    else $error("target store irq missing");
  AST_IRQ_RES: assert property ((ce_evt[3] | ue_evt[3]) |-> ##2 irq_virtual_target_residency)
    else $error("residency irq missing");
  AST_IRQ_SRC: assert property ((ce_evt[4] | ue_evt[4]) |-> ##2 irq_virtual_target_search)
    else $error("search irq missing");
  // ------------------------------------------------------------
  // target store level only drops after a software clear; read data is zero outside the answer cycle
  // ------------------------------------------------------------
  AST_IRQ_FALL: assert property ($past(rst_n) && $fell(irq_virtual_target_store) |-> $past(reg_wr, 2))
    else $error("target store irq dropped without clear");
  AST_RD_IDLE: assert property ($past(rst_n) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  // ------------------------------------------------------------
  // translation refetch follows each uncorrectable error
  // ------------------------------------------------------------
  AST_REFETCH: assert property (ue_evt[5] |=> its_refetch_req
    && its_refetch_addr == $past(evt_addr[5]) && its_refetch_ram == $past(its_ram_sel))
    else $error("refetch request wrong");
  AST_REFETCH_CAUSE: assert property ($past(rst_n) && its_refetch_req |-> $past(ue_evt[5]))
    else $error("refetch without cause");
endmodule

bind vrec_top vrec_top_chk vrec_top_chk_i (
  .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ce_evt(ce_evt), .ue_evt(ue_evt), .evt_addr(evt_addr),
  .its_ram_sel(its_ram_sel), .irq_virtual_comm_cache(irq_virtual_comm_cache),
  .irq_virtual_sgi_pending_array(irq_virtual_sgi_pending_array),
  .irq_virtual_target_store(irq_virtual_target_store),
  .irq_virtual_target_residency(irq_virtual_target_residency),
  .irq_virtual_target_search(irq_virtual_target_search),
  .its_refetch_req(its_refetch_req), .its_refetch_ram(its_refetch_ram),
  .its_refetch_addr(its_refetch_addr));

// >>> tb/vrec_top_tb.sv
// self-checking bench for the virtual RAM ECC error record block
`include "vrec_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); miscompares++; end end
module vrec_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                           core_clk, rst_n, reg_wr, reg_rd, its_refetch_req;
  logic [7:0]                     reg_addr, its_index;
  logic [31:0]                    reg_wdata, reg_rdata, its_refetch_addr, d, rnd, bl, ad;
  logic [1:0]                     its_ram_sel, its_refetch_ram;
  logic [5:0]                     rec;
  logic [4:0]                     irq;
  logic [`VREC_NUM_SRC-1:0]       ce_evt, ue_evt;
  logic [`VREC_NUM_SRC-1:0][31:0] evt_bitloc, evt_addr;
  int                             miscompares, samples_checked, s;
  bit                             u;
  vrec_top vrec_top_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ce_evt(ce_evt), .ue_evt(ue_evt), .evt_bitloc(evt_bitloc), .evt_addr(evt_addr),
    .its_index(its_index), .its_ram_sel(its_ram_sel),
    .irq_virtual_comm_cache(irq[0]), .irq_virtual_sgi_pending_array(irq[1]),
    .irq_virtual_target_store(irq[2]), .irq_virtual_target_residency(irq[3]),
    .irq_virtual_target_search(irq[4]), .its_refetch_req(its_refetch_req),
    .its_refetch_ram(its_refetch_ram), .its_refetch_addr(its_refetch_addr));
  // ------------------------------------------------------------
  // stimulus helpers and expected syndromes
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] exp_syn(input int s, input bit u,
    input logic [31:0] b, a, input logic [7:0] ix, input logic [1:0] sl);
    logic [31:0] m;
    m = (32'h1 << ((s == 2) ? 10 : (s == 1 || s == 4) ? 3 : 4)) - 32'h1;
    if (s == 5) return u ? {a[27:0], 1'b0, sl, ix[0]} : {a[20:0], b[7:0], sl, ix[0]};
    return u ? (a & m) : ((b << ((s == 2) ? 10 : (s == 1 || s == 4) ? 3 : 4)) | (a & m));
  endfunction
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic fire(input int s, input bit u, input logic [31:0] b, a);
    @(posedge core_clk);
    if (u) ue_evt[s] <= 1'b1;
    else ce_evt[s] <= 1'b1;
    evt_bitloc[s] <= b;
    evt_addr[s] <= a;
    @(posedge core_clk);
    ce_evt <= '0;
    ue_evt <= '0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
  // ------------------------------------------------------------
  // corner records first, then random ones; set, overflow, clear
  // ------------------------------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, its_index, its_ram_sel} = '0;
    {ce_evt, ue_evt, evt_bitloc, evt_addr} = '0;
    rnd = 32'h45BB43FD;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h4F, d);
    `CHK("reset status", 32'h0, d)
    `CHK("reset irq", 5'h00, irq)
    for (int n = 0; n < 48; n++) begin
      rnd = lfsr(rnd);
      s = (n < 24) ? n % 6 : rnd[2:0] % 6;
      u = (n < 24) ? (n / 6) % 2 : rnd[3];
      its_ram_sel <= (n < 24) ? 2'(n / 6) : rnd[5:4];
      its_index <= rnd[15:8];
      bl = lfsr(rnd);
      ad = (n < 12) ? '1 : lfsr(bl);
      rec = 6'(15 + 2 * s + int'(u));
      fire(s, u, bl, ad);
      rd({2'b00, rec}, d);
      `CHK("syndrome", exp_syn(s, u, bl, ad, its_index, its_ram_sel), d)
      rd({2'b01, rec}, d);
      `CHK("status", 32'h1, d)
      if (s < 5) `CHK("irq set", 1'b1, irq[s])
      fire(s, u, ~bl, ~ad);
      rd({2'b00, rec}, d);
      `CHK("held", exp_syn(s, u, bl, ad, its_index, its_ram_sel), d)
      if (s == 5 && u) `CHK("refetch addr", ~ad, its_refetch_addr)
      if (s == 5 && u) `CHK("refetch ram", its_ram_sel, its_refetch_ram)
      `CHK("refetch pulse", 1'b0, its_refetch_req)
      rd({2'b01, rec}, d);
      `CHK("overflow", 32'h3, d)
      wr({2'b01, rec}, 32'h1);
      rd({2'b01, rec}, d);
      `CHK("cleared", 32'h0, d)
      if (s < 5) `CHK("irq clear", 1'b0, irq[s])
    end
    // hand corner: target store capture, then event and clear on one edge
    fire(2, 1'b0, 32'h5, 32'h3);
    rd({2'b00, 6'h13}, d);
    `CHK("walk syndrome", 32'h00001403, d)
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= {2'b01, 6'h13};
    reg_wdata <= 32'h1;
    ce_evt[2] <= 1'b1;
    evt_bitloc[2] <= 32'h9;
    evt_addr[2] <= 32'h7;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    ce_evt <= '0;
    rd({2'b01, 6'h13}, d);
    `CHK("set beats clear", 32'h1, d)
    rd({2'b00, 6'h13}, d);
    `CHK("recaptured", exp_syn(2, 1'b0, 32'h9, 32'h7, its_index, its_ram_sel), d)
    `CHK("irq kept", 1'b1, irq[2])
    wr({2'b01, 6'h13}, 32'h1);
    rd({2'b01, 6'h13}, d);
    `CHK("cleared again", 32'h0, d)
    `CHK("irq dropped", 1'b0, irq[2])
    rd(8'h3F, d);
    `CHK("unmapped", 32'h0, d)
    rd(`VREC_CFG_ADDR, d);
    `CHK("config", 32'h00014283, d)
    summarize();
  end
endmodule
